// [logic/xfer_consts.svh]
`ifndef XFER_CONSTS_SVH
`define XFER_CONSTS_SVH
// Register offset on the plain register port
`define OFS_CONTROL_STATUS 4'h0
// Field positions in transfer_control_status
`define BIT_STOP_FLAG      0
`define BIT_CHAIN_RPT_EN   3
`define BIT_SKIP_EN        4
// Reset value of transfer_control_status
`define RST_CONTROL_STATUS 8'h00
`endif

// [logic/xfer_pkg.sv]
`default_nettype none
package xfer_pkg;
   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_VEC,
      ST_INFO,
      ST_XFER
   } seq_state_t;
endpackage
`default_nettype wire

// [logic/transfer_ctrl_skip_error.sv]
// Our own choices: the address-and-strobe port and the placing of the registers.
`include "xfer_consts.svh"
`default_nettype none
module transfer_ctrl_skip_error
   import xfer_pkg::*;
#(
   parameter int VEC_W = 8
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rstn,
   // Register port
   input  wire logic [3:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [7:0]       reg_rdata,
   // Activation request
   input  wire logic             act_req,
   input  wire logic [VEC_W-1:0] act_vector,
   output logic                  act_ready,
   // Vector and information fetch
   output logic                  fetch_req,
   output logic                  fetch_is_vec,
   input  wire logic             fetch_ack,
   input  wire logic             fetch_info_repeat,
   input  wire logic             fetch_info_chain,
   input  wire logic [15:0]      fetch_info_count,
   // Data unit transfer
   output logic                  data_req,
   input  wire logic             data_ack,
   // Stop events
   input  wire logic             addr_err,
   input  wire logic             nmi,
   // Status
   output logic                  act_done,
   output logic                  info_skipped,
   output logic                  stopped
);

   seq_state_t       state_ff, nxt_state;
   logic [VEC_W-1:0] prev_vec_ff, nxt_prev_vec;
   logic             prev_valid_ff, nxt_prev_valid;
   logic             last_chain_ff, nxt_last_chain;
   logic             rpt_mode_ff, nxt_rpt_mode;
   logic             chain_ff, nxt_chain;
   logic [15:0]      count_ff, nxt_count;
   logic             skip_en_ff, nxt_skip_en;
   logic             chain_en_ff, nxt_chain_en;
   logic             stop_ff, nxt_stop;
   logic             armed_ff, nxt_armed;
   logic [7:0]       rdata_ff, nxt_rdata;
   logic             done_ff, nxt_done;
   logic             skipped_ff, nxt_skipped;
   logic             take_act;
   logic             vec_match;
   logic             skip_now;
   logic             stop_event;
   logic             ctl_wr;
   logic [7:0]       cnt_lo_dec;
   logic             rpt_reload;
   logic             xfer_last;
   logic             chain_ok;

   // Handshake outputs are combinational from state
   assign act_ready    = (state_ff == ST_IDLE) && !stop_ff;
   assign fetch_req    = ((state_ff == ST_VEC) || (state_ff == ST_INFO)) && !stop_ff;
   assign fetch_is_vec = (state_ff == ST_VEC);
   assign data_req     = (state_ff == ST_XFER) && !stop_ff;
   assign reg_rdata    = rdata_ff;
   assign act_done     = done_ff;
   assign info_skipped = skipped_ff;
   assign stopped      = stop_ff;

   // Decode helpers
   assign take_act   = act_req && act_ready;
   assign stop_event = addr_err || nmi;
   assign ctl_wr     = reg_wr && (reg_addr == `OFS_CONTROL_STATUS);
   assign vec_match  = prev_valid_ff && (act_vector == prev_vec_ff);
   // skip decision; chain history forbids it
   assign skip_now   = skip_en_ff && vec_match && !last_chain_ff;
   assign cnt_lo_dec = count_ff[7:0] - 8'h01;
   assign rpt_reload = rpt_mode_ff && (cnt_lo_dec == 8'h00);
   assign xfer_last  = rpt_mode_ff ? rpt_reload : (count_ff == 16'h0001);
   // chain after reload needs the enable
   assign chain_ok   = chain_ff && xfer_last && (!rpt_mode_ff || chain_en_ff);

   // Next-state logic for sequencer and register
   always_comb begin
      nxt_state      = state_ff;
      nxt_prev_vec   = prev_vec_ff;
      nxt_prev_valid = prev_valid_ff;
      nxt_last_chain = last_chain_ff;
      nxt_rpt_mode   = rpt_mode_ff;
      nxt_chain      = chain_ff;
      nxt_count      = count_ff;
      nxt_skip_en    = skip_en_ff;
      nxt_chain_en   = chain_en_ff;
      nxt_stop       = stop_ff;
      nxt_armed      = armed_ff;
      nxt_rdata      = 8'h00;
      nxt_done       = 1'b0;
      nxt_skipped    = 1'b0;

      // Read data stand one cycle only
      if (reg_rd && (reg_addr == `OFS_CONTROL_STATUS)) begin
         // upper bits read zero; bits 2:1 read zero
         nxt_rdata[`BIT_SKIP_EN]      = skip_en_ff;
         nxt_rdata[`BIT_CHAIN_RPT_EN] = chain_en_ff;
         nxt_rdata[`BIT_STOP_FLAG]    = stop_ff;
         if (stop_ff) begin
            nxt_armed = 1'b1;
         end
      end

      // Writable enables; reserved bits simply not stored
      if (ctl_wr) begin
         nxt_skip_en  = reg_wdata[`BIT_SKIP_EN];
         nxt_chain_en = reg_wdata[`BIT_CHAIN_RPT_EN];
         // clear only after a read of 1, writing 1 ignored
         if (armed_ff && !reg_wdata[`BIT_STOP_FLAG]) begin
            nxt_stop = 1'b0;
         end
         nxt_armed = 1'b0;
      end

      case (state_ff)
         ST_IDLE: begin
            if (take_act) begin
               nxt_prev_vec   = act_vector;
               nxt_prev_valid = 1'b1;
               // fresh activation starts without chain history
               nxt_last_chain = 1'b0;
               if (skip_now) begin
                  nxt_state   = ST_XFER;
                  nxt_skipped = 1'b1;
               end else begin
                  nxt_state = ST_VEC;
               end
            end
         end
         ST_VEC: begin
            if (fetch_ack) begin
               nxt_state = ST_INFO;
            end
         end
         ST_INFO: begin
            if (fetch_ack) begin
               nxt_rpt_mode = fetch_info_repeat;
               nxt_chain    = fetch_info_chain;
               nxt_count    = fetch_info_count;
               nxt_state    = ST_XFER;
            end
         end
         ST_XFER: begin
            if (data_ack) begin
               if (rpt_mode_ff) begin
                  // reload lower byte from upper byte at zero
                  nxt_count[7:0] = rpt_reload ? count_ff[15:8] : cnt_lo_dec;
               end else begin
                  nxt_count = count_ff - 16'h0001;
               end
               if (chain_ok) begin
                  // Chained info follows the current one in the table
                  nxt_state      = ST_INFO;
                  nxt_last_chain = 1'b1;
               end else begin
                  // Chain history kept so the next activation refetches
                  nxt_state      = ST_IDLE;
                  nxt_done       = 1'b1;
               end
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase

      // stop halts everything; set wins over a clear
      // history dropped so the next activation fetches fully
      if (stop_event) begin
         nxt_stop       = 1'b1;
         nxt_state      = ST_IDLE;
         nxt_prev_valid = 1'b0;
         nxt_last_chain = 1'b0;
         nxt_done       = 1'b0;
         nxt_skipped    = 1'b0;
      end
   end

   // Registers; reset leaves history invalid
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state_ff      <= ST_IDLE;
         prev_vec_ff   <= '0;
         prev_valid_ff <= 1'b0;
         last_chain_ff <= 1'b0;
         rpt_mode_ff   <= 1'b0;
         chain_ff      <= 1'b0;
         count_ff      <= 16'h0000;
         skip_en_ff    <= 1'b0;
         chain_en_ff   <= 1'b0;
         stop_ff       <= 1'b0;
         armed_ff      <= 1'b0;
         rdata_ff      <= `RST_CONTROL_STATUS;
         done_ff       <= 1'b0;
         skipped_ff    <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         prev_vec_ff   <= nxt_prev_vec;
         prev_valid_ff <= nxt_prev_valid;
         last_chain_ff <= nxt_last_chain;
         rpt_mode_ff   <= nxt_rpt_mode;
         chain_ff      <= nxt_chain;
         count_ff      <= nxt_count;
         skip_en_ff    <= nxt_skip_en;
         chain_en_ff   <= nxt_chain_en;
         stop_ff       <= nxt_stop;
         armed_ff      <= nxt_armed;
         rdata_ff      <= nxt_rdata;
         done_ff       <= nxt_done;
         skipped_ff    <= nxt_skipped;
      end
   end

   // skipped activation goes straight to data
   chk_skip_to_xfer: assert property (@(posedge mclk) disable iff (!rstn)
      take_act && skip_now && !stop_event |=> (state_ff == ST_XFER) && info_skipped)
      else $error("skipped activation did not start data transfer");

   // full activation fetches vector then info
   chk_full_fetch: assert property (@(posedge mclk) disable iff (!rstn)
      take_act && !skip_now && !stop_event |=> fetch_req && fetch_is_vec)
      else $error("non-skipped activation did not fetch vector");

   chk_vec_then_info: assert property (@(posedge mclk) disable iff (!rstn)
      (state_ff == ST_VEC) && fetch_ack && !stop_event |=> (state_ff == ST_INFO) && !fetch_is_vec)
      else $error("info fetch did not follow vector fetch");

   chk_chain_refetch: assert property (@(posedge mclk) disable iff (!rstn)
      take_act && last_chain_ff && !stop_event |=> state_ff == ST_VEC)
      else $error("activation after chain skipped the fetch");

   chk_rpt_reload: assert property (@(posedge mclk) disable iff (!rstn)
      data_ack && data_req && rpt_mode_ff && (count_ff[7:0] == 8'h01) |=> count_ff[7:0] == $past(count_ff[15:8]))
      else $error("repeat counter not reloaded at zero");

   // no chain after reload when disabled
   chk_no_rpt_chain: assert property (@(posedge mclk) disable iff (!rstn)
      data_ack && data_req && rpt_reload && !chain_en_ff && !stop_event |=> state_ff == ST_IDLE && act_done)
      else $error("chain taken after repeat reload while disabled");

   // stop event sets flag and halts requests
   chk_stop_halt: assert property (@(posedge mclk) disable iff (!rstn)
      stop_event |=> stopped && !data_req && !fetch_req && !act_ready)
      else $error("stop event did not halt transfers");

   // flag survives a write without prior read of 1
   chk_clear_guard: assert property (@(posedge mclk) disable iff (!rstn)
      stop_ff && !armed_ff |=> stop_ff)
      else $error("stop flag cleared without read of 1");

   chk_reserved_zero: assert property (@(posedge mclk) disable iff (!rstn)
      reg_rd |=> (reg_rdata[7:5] == 3'h0) && (reg_rdata[2:1] == 2'h0))
      else $error("reserved bits read nonzero");

   chk_hist_invalid: assert property (@(posedge mclk) disable iff (!rstn)
      stop_event |=> !prev_valid_ff ##1 (!take_act || !skip_now))
      else $error("vector history kept across stop");

   chk_skip_off_fetch: assert property (@(posedge mclk) disable iff (!rstn)
      take_act && !skip_en_ff && !stop_event |=> state_ff == ST_VEC)
      else $error("activation skipped fetch while skip disabled");

   // writing 1 never changes the flag
   chk_write_one_kept: assert property (@(posedge mclk) disable iff (!rstn)
      ctl_wr && reg_wdata[`BIT_STOP_FLAG] && !stop_event |=> stop_ff == $past(stop_ff))
      else $error("write of 1 changed stop flag");

   // read data stand one cycle, else zero
   chk_rdata_idle: assert property (@(posedge mclk) disable iff (!rstn)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data nonzero outside read cycle");

endmodule // transfer_ctrl_skip_error
`default_nettype wire

// [bench/xfer_bus_model.sv]
`default_nettype none
module xfer_bus_model (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Requests from the controller
   input  wire logic        fetch_req,
   input  wire logic        fetch_is_vec,
   input  wire logic        data_req,
   // Scenario settings
   input  wire logic        cfg_rep,
   input  wire logic        cfg_chain,
   input  wire logic [15:0] cfg_cnt,
   input  wire logic [1:0]  slow,
   // Answers
   output logic             fetch_ack,
   output logic             info_rep,
   output logic             info_chain,
   output logic [15:0]      info_cnt,
   output logic             data_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_ff;
   logic       ack_ff;
   logic       vec_ff;
   // Ack after slow wait cycles; a pulse, never two in a row
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wait_ff <= 2'h0;
         ack_ff  <= 1'b0;
         vec_ff  <= 1'b0;
      end else begin
         ack_ff  <= (fetch_req || data_req) && !ack_ff && wait_ff >= slow;
         wait_ff <= ((fetch_req || data_req) && !ack_ff) ? wait_ff + 2'h1 : 2'h0;
         if (ack_ff && fetch_req) vec_ff <= fetch_is_vec;
      end
   end
   // Chain only on the first element, so a chain ends
   assign fetch_ack  = ack_ff && fetch_req;
   assign data_ack   = ack_ff && data_req;
   assign info_rep   = fetch_ack ? cfg_rep : ~cfg_rep;
   assign info_chain = fetch_ack ? cfg_chain && vec_ff : ~cfg_chain;
   assign info_cnt   = fetch_ack ? cfg_cnt : ~cfg_cnt;
endmodule // xfer_bus_model
`default_nettype wire

// [bench/transfer_ctrl_skip_error_tb_top.sv]
`default_nettype none
module transfer_ctrl_skip_error_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
   logic        act_req = 0, addr_err = 0, nmi = 0, cfg_rep = 0, cfg_chain = 0;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00, act_vector = 8'h00, reg_rdata, fcnt = 8'h00;
   logic [15:0] cfg_cnt = 16'h0002, f_cnt;
   logic [1:0]  slow = 2'h0;
   logic        act_ready, fetch_req, fetch_is_vec, fetch_ack, f_rep, f_chain;
   logic        data_req, data_ack, act_done, info_skipped, stopped, skip_seen = 0;
   int          err_total = 0, checks = 0, cyc = 0;
   transfer_ctrl_skip_error u_transfer_ctrl_skip_error (.mclk(mclk), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .act_req(act_req), .act_vector(act_vector), .act_ready(act_ready),
      .fetch_req(fetch_req), .fetch_is_vec(fetch_is_vec), .fetch_ack(fetch_ack),
      .fetch_info_repeat(f_rep), .fetch_info_chain(f_chain), .fetch_info_count(f_cnt),
      .data_req(data_req), .data_ack(data_ack), .addr_err(addr_err), .nmi(nmi),
      .act_done(act_done), .info_skipped(info_skipped), .stopped(stopped));
   xfer_bus_model u_xfer_bus_model (.mclk(mclk), .rstn(rstn), .fetch_req(fetch_req),
      .fetch_is_vec(fetch_is_vec), .data_req(data_req), .cfg_rep(cfg_rep), .cfg_chain(cfg_chain),
      .cfg_cnt(cfg_cnt), .slow(slow), .fetch_ack(fetch_ack), .info_rep(f_rep),
      .info_chain(f_chain), .info_cnt(f_cnt), .data_ack(data_ack));
   // Clock
   always #50 mclk = ~mclk;
   // Fetch counting, skip tracking and hang guard
   always @(posedge mclk) begin
      cyc++;
      if (fetch_req === 1'b1 && fetch_ack === 1'b1) fcnt++;
      if (info_skipped === 1'b1) skip_seen = 1'b1;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (err_total == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge mclk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge mclk) reg_rd <= 1'b0;
      @(posedge mclk) chk("rdata", exp, reg_rdata);
   endtask
   // One activation: count fetches, note the skip path
   task automatic act(input logic [7:0] v, input logic [7:0] nf, input logic sk);
      int n;
      n = 0;
      fcnt = 8'h00;
      skip_seen = 1'b0;
      @(posedge mclk) {act_req, act_vector} <= {1'b1, v};
      do @(posedge mclk); while (act_ready !== 1'b1 && ++n < 50);
      act_req <= 1'b0;
      while (act_done !== 1'b1 && n < 150) begin
         @(posedge mclk);
         n++;
      end
      chk("act_done", 8'h01, {7'h00, act_done});
      chk("fetches", nf, fcnt);
      chk("skipped", {7'h00, sk}, {7'h00, skip_seen});
   endtask
   task automatic t_regs();
      rd(4'h0, 8'h00);
      wr(4'h0, 8'hFF);
      rd(4'h0, 8'h18);
      rd(4'h5, 8'h00);
      wr(4'h0, 8'h00);
   endtask
   task automatic t_skip();
      act(8'h05, 8'h02, 1'b0);
      act(8'h05, 8'h02, 1'b0);
      wr(4'h0, 8'h10);
      act(8'h05, 8'h00, 1'b1);
      act(8'h06, 8'h02, 1'b0);
      {cfg_chain, cfg_cnt} = {1'b1, 16'h0001};
      act(8'h07, 8'h03, 1'b0);
      act(8'h07, 8'h03, 1'b0);
   endtask
   task automatic t_repeat();
      {cfg_rep, cfg_cnt} = {1'b1, 16'h0201};
      act(8'h08, 8'h02, 1'b0);
      wr(4'h0, 8'h18);
      cfg_cnt = 16'h0202;
      act(8'h09, 8'h02, 1'b0);
      act(8'h09, 8'h01, 1'b1);
      act(8'h09, 8'h02, 1'b0);
   endtask
   // Each stop source, then the read-then-clear handshake
   task automatic t_stop();
      slow = 2'h2;
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk) {nmi, addr_err} <= (i == 0) ? 2'b10 : 2'b01;
         @(posedge mclk) {nmi, addr_err} <= 2'b00;
         @(posedge mclk) chk("stopped", 8'h01, {7'h00, stopped});
         chk("act_ready", 8'h00, {7'h00, act_ready});
         wr(4'h0, 8'h18);
         @(posedge mclk) chk("stopped", 8'h01, {7'h00, stopped});
         rd(4'h0, 8'h19);
         wr(4'h0, 8'h18);
         @(posedge mclk) chk("stopped", 8'h00, {7'h00, stopped});
         act(8'h09, 8'h02, 1'b0);
      end
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      t_regs();
      t_skip();
      t_repeat();
      t_stop();
      stop_test();
   end
endmodule // transfer_ctrl_skip_error_tb_top
`default_nettype wire
